/* File: swb_pkg.sv */
// constants for the white-balance and sensor-interface register bank
package swb_pkg;
  localparam int          NREG        = 15;      // locally held configuration registers
  localparam int          IDX_W       = 4;       // width of a local register index
  localparam logic [3:0]  IDX_NONE    = 4'hf;    // no local register at this address
  localparam int          GAIN_W      = 19;      // gain in units of 0.00001
  localparam int          CODE_W      = 6;       // colour gain code width
  // local register indices
  localparam logic [3:0]  I_COL1      = 4'h0;
  localparam logic [3:0]  I_COL2      = 4'h1;
  localparam logic [3:0]  I_COL3      = 4'h2;
  localparam logic [3:0]  I_COL4      = 4'h3;
  localparam logic [3:0]  I_VFW_HI    = 4'h4;
  localparam logic [3:0]  I_VFW_LO    = 4'h5;
  localparam logic [3:0]  I_SOF       = 4'h6;
  localparam logic [3:0]  I_VIDEO_CLOCK      = 4'h7;
  localparam logic [3:0]  I_LEN       = 4'h8;
  localparam logic [3:0]  I_READOUT   = 4'h9;
  localparam logic [3:0]  I_SHS       = 4'ha;
  localparam logic [3:0]  I_SHR       = 4'hb;
  localparam logic [3:0]  I_HCLK      = 4'hc;
  localparam logic [3:0]  I_PIX       = 4'hd;
  localparam logic [3:0]  I_FRC       = 4'he;
  // byte addresses, in index order
  localparam logic [7:0]  ADDR_TAB [NREG] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h52, 8'h53, 8'h54, 8'h55,
                                              8'h56, 8'h57, 8'h5f, 8'h60, 8'h64, 8'h65, 8'h67};
  // reset values, in index order
  localparam logic [7:0]  RST_TAB [NREG]  = '{8'h0e, 8'h0e, 8'h0e, 8'h0e, 8'h05, 8'h13, 8'h4c, 8'h02,
                                              8'h0e, 8'h04, 8'h0a, 8'h0a, 8'h5c, 8'h00, 8'h24};
  // bit set where the register only reaches the sensor at a frame boundary
  localparam logic [14:0] SHADOW_MASK = 15'h1c3f;
  localparam int          COLOUR_REGS = 4;       // indices below this hold gain codes
  localparam logic [7:0]  CODE_MASK   = 8'h3f;
  localparam logic [7:0]  A_COF_LO    = 8'h80;
  localparam logic [7:0]  A_COF_HI    = 8'hbf;
  localparam logic [7:0]  A_DECODE_HI = 8'hbf;   // top of the decoded range
  // gain figures, scaled by 100000
  localparam logic [18:0] GAIN_BASE   = 19'h10fb8;  // 0.6956
  localparam logic [18:0] RAW_LO_STEP = 19'h0087e;  // 0.02174
  localparam logic [18:0] GAIN_STEP   = 19'h010f4;  // 0.0434
  localparam logic [18:0] RAW_HI_BASE = 19'h21f5c;  // 1.391
  localparam logic [5:0]  RAW_KNEE    = 6'h20;      // code 32
endpackage

/* File: swb_coeff_mem.sv */
// column offset coefficient store with two registered read ports
`timescale 1ns/1ps
module swb_coeff_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          ref_clk,    // master clock
  input  wire logic          rst_n,      // synchronised reset, active low
  input  wire logic          wr_en,      // write strobe
  input  wire logic [AW-1:0] wr_addr,    // write index
  input  wire logic [W-1:0]  wr_data,    // write data
  input  wire logic [AW-1:0] rd_a_addr,  // host read index
  output logic      [W-1:0]  rd_a_data,  // host read data, registered
  input  wire logic [AW-1:0] rd_b_addr,  // datapath read index
  output logic      [W-1:0]  rd_b_data   // datapath read data, registered
);
  // the index must cover the store exactly, or some coefficients would alias
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("swb_coeff_mem: DEPTH must be 2**AW");
  end

  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];

  // write path
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en) begin
      next_mem[wr_addr] = wr_data;
    end
  end

  // every coefficient clears to zero at reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0; // R16
      end
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      mem       <= next_mem;
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end
endmodule

/* File: swb_reg_bank.sv */
// white-balance gain and sensor-interface register bank
`timescale 1ns/1ps
// What this block does
// R1: four colour gain registers hold six-bit codes in bits 5:0, bits 7:6 unused.
// R2: colour gain one at address 00h is green-red green, two at 01h is red.
// R3: raw mode, codes 0..32: gain is 0.6956 plus 0.02174 times code.
// R4: raw mode, codes 33..63: gain is 1.391 plus 0.0434 times (code-32).
// R5: linear mode: gain is 0.6956 plus 0.0434 times code.
// R6: raw or linear function chosen by the separate gain mode setting.
// R7: every colour gain register resets to a code that gives unity gain in raw mode.
// R8: colour gain registers reset to 0Eh and are shadowed.
// R9: shadowed values reach the timing logic only at a frame boundary.
// R10: registers 52h, 53h, 5Fh, 60h and 64h are shadowed.
// R11: registers 54h to 57h act at once, without waiting for a frame.
// R12: reset values 4Ch, 02h, 0Eh, 04h for registers 54h to 57h.
// R13: virtual frame width resets to 05h upper, 13h lower, one split value.
// R14: signal-sample and reset-sample timing registers reset to 0Ah.
// R15: reset values 5Ch at 64h, 00h at 65h, 24h at 67h.
// R16: addresses 80h..BFh hold 64 column offset coefficients, reset zero.
// R17: the bank decodes register addresses 00h up to BFh.
// R18: unused addresses read zero and ignore writes.
module swb_reg_bank #(
  parameter int COEFFS = 64  // column offset coefficient count
) (
  input  wire logic        ref_clk,            // master clock, 100 MHz
  input  wire logic        nrst,               // reset, active low, asynchronous
  input  wire logic [7:0]  reg_addr,           // internal register address
  input  wire logic [7:0]  reg_wdata,          // write data
  input  wire logic        reg_wr,             // write strobe, one cycle
  input  wire logic        reg_rd,             // read strobe, one cycle
  output logic      [7:0]  reg_rdata,          // read data, registered
  output logic             reg_rvalid,         // read data valid pulse
  input  wire logic        frame_boundary,     // frame boundary pulse from timing
  input  wire logic        gain_mode_linear,   // white-balance gain mode, high = linear
  input  wire logic [5:0]  col_index,          // column number modulo 64
  output logic      [7:0]  col_offset,         // coefficient for col_index, registered
  output logic      [18:0] gain_colour1,       // green of green-red row gain
  output logic      [18:0] gain_colour2,       // red gain
  output logic      [18:0] gain_colour3,       // blue gain
  output logic      [18:0] gain_colour4,       // green of blue-green row gain
  output logic      [15:0] vframe_width,       // virtual frame column width
  output logic      [7:0]  frame_start_delay,  // start-of-frame delay
  output logic      [7:0]  video_clock_delay,  // video clock delay
  output logic      [7:0]  sync_pulse_len,     // sync pulse length control
  output logic      [7:0]  readout_coding,     // readout coding control
  output logic      [7:0]  signal_sample_time, // signal sample time
  output logic      [7:0]  reset_sample_time,  // reset sample time
  output logic      [7:0]  line_clock_delay,   // line clock delay
  output logic      [7:0]  pixel_stream_ctrl,  // pixel data stream control
  output logic      [7:0]  frame_rate_ctrl     // frame rate control definition
);
  // column port is six bits and the local index four, so other sizes cannot be served
  if (COEFFS != 64) begin : g_bad_coeffs
    $error("swb_reg_bank: coefficient window is fixed at 64");
  end
  if (swb_pkg::NREG >= (1 << swb_pkg::IDX_W)) begin : g_bad_index
    $error("swb_reg_bank: local index cannot hold every register and the none code");
  end

  // address to local index; anything not listed is unused or coefficient space
  function automatic logic [3:0] find_idx(input logic [7:0] a);
    logic [3:0] r;
    r = swb_pkg::IDX_NONE;
    for (int i = 0; i < swb_pkg::NREG; i++) begin
      if (swb_pkg::ADDR_TAB[i] == a) r = 4'(i); // R2 R17
    end
    return r;
  endfunction

  function automatic logic is_coeff(input logic [7:0] a);
    return (a >= swb_pkg::A_COF_LO) && (a <= swb_pkg::A_COF_HI); // R16 R17
  endfunction

  // code to gain in units of 0.00001
  function automatic logic [18:0] gain_of(input logic [5:0] c, input logic lin);
    logic [18:0] cw;
    logic [18:0] g;
    cw = {13'h0000, c};
    if (lin) begin
      g = 19'(swb_pkg::GAIN_BASE + 19'(swb_pkg::GAIN_STEP * cw)); // R5
    end else if (c <= swb_pkg::RAW_KNEE) begin
      g = 19'(swb_pkg::GAIN_BASE + 19'(swb_pkg::RAW_LO_STEP * cw)); // R3
    end else begin
      g = 19'(swb_pkg::RAW_HI_BASE + 19'(swb_pkg::GAIN_STEP * 19'(cw - 19'h00020))); // R4
    end
    return g;
  endfunction

  // assert reaches every flop at once; release is clocked so no flop leaves reset early
  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // two copies per register: what the host wrote, and what the timing logic uses
  logic [7:0]  cfg [swb_pkg::NREG];       // host-visible copies
  logic [7:0]  act [swb_pkg::NREG];       // copies seen by timing logic
  logic [7:0]  next_cfg [swb_pkg::NREG];
  logic [7:0]  next_act [swb_pkg::NREG];
  logic [3:0]  wr_idx;
  logic [3:0]  rd_idx;
  logic [7:0]  mem_rdata;
  logic        rd_q;
  logic        rd_coeff_q;
  logic [7:0]  rd_loc_q;
  logic [7:0]  next_rdata;
  logic [18:0] next_gain [swb_pkg::COLOUR_REGS];
  logic [18:0] gain_q [swb_pkg::COLOUR_REGS];

  // one decode serves both strobes; reads and writes never differ in address handling
  assign wr_idx = find_idx(reg_addr);
  assign rd_idx = find_idx(reg_addr);

  // host writes land in cfg; gain codes keep only their six bits
  always_comb begin
    for (int i = 0; i < swb_pkg::NREG; i++) begin
      next_cfg[i] = cfg[i];
    end
    if (reg_wr && (wr_idx != swb_pkg::IDX_NONE)) begin // R18
      if (wr_idx < 4'(swb_pkg::COLOUR_REGS)) begin
        next_cfg[wr_idx] = reg_wdata & swb_pkg::CODE_MASK; // R1
      end else begin
        next_cfg[wr_idx] = reg_wdata;
      end
    end
  end

  // shadowed entries follow cfg only on a frame boundary, the rest follow at once
  always_comb begin
    for (int i = 0; i < swb_pkg::NREG; i++) begin
      if (!swb_pkg::SHADOW_MASK[i]) begin
        next_act[i] = next_cfg[i]; // R11
      end else if (frame_boundary) begin
        next_act[i] = cfg[i]; // R9 R10 R8
      end else begin
        next_act[i] = act[i]; // R9
      end
    end
  end

  // both copies start from the documented reset values
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < swb_pkg::NREG; i++) begin
        cfg[i] <= swb_pkg::RST_TAB[i]; // R7 R8 R12 R13 R14 R15
        act[i] <= swb_pkg::RST_TAB[i];
      end
    end else begin
      cfg <= next_cfg;
      act <= next_act;
    end
  end

  // gains from the active codes, mode chosen live
  always_comb begin
    for (int i = 0; i < swb_pkg::COLOUR_REGS; i++) begin
      next_gain[i] = gain_of(act[i][5:0], gain_mode_linear); // R6
    end
  end

  // gains start at the code-zero figure; the first edge out of reset loads the reset code
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < swb_pkg::COLOUR_REGS; i++) begin
        gain_q[i] <= swb_pkg::GAIN_BASE;
      end
    end else begin
      gain_q <= next_gain;
    end
  end

  // coefficients live in their own store; one port for the host, one for the datapath
  swb_coeff_mem #(
    .W     (8),
    .DEPTH (COEFFS),
    .AW    (6)
  ) u_coeff (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .wr_en     (reg_wr && is_coeff(reg_addr)),
    .wr_addr   (reg_addr[5:0]),
    .wr_data   (reg_wdata),
    .rd_a_addr (reg_addr[5:0]),
    .rd_a_data (mem_rdata),
    .rd_b_addr (col_index),
    .rd_b_data (col_offset)
  );

  // read in two stages so the memory's registered output can be muxed into a flop
  always_comb begin
    if (rd_coeff_q) begin
      next_rdata = mem_rdata; // R16
    end else begin
      next_rdata = rd_loc_q;
    end
  end

  // rvalid and rdata rise together and fall back together after one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q       <= 1'b0;
      rd_coeff_q <= 1'b0;
      rd_loc_q   <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_rdata  <= 8'h00;
    end else begin
      rd_q       <= reg_rd;
      rd_coeff_q <= reg_rd && is_coeff(reg_addr);
      rd_loc_q   <= (rd_idx == swb_pkg::IDX_NONE) ? 8'h00 : cfg[rd_idx]; // R18
      reg_rvalid <= rd_q;
      reg_rdata  <= rd_q ? next_rdata : 8'h00;
    end
  end

  // active copies drive the timing logic; host reads never see them
  assign gain_colour1       = gain_q[0];
  assign gain_colour2       = gain_q[1];
  assign gain_colour3       = gain_q[2];
  assign gain_colour4       = gain_q[3];
  assign vframe_width       = {act[swb_pkg::I_VFW_HI], act[swb_pkg::I_VFW_LO]}; // R13
  assign frame_start_delay  = act[swb_pkg::I_SOF];
  assign video_clock_delay  = act[swb_pkg::I_VIDEO_CLOCK];
  assign sync_pulse_len     = act[swb_pkg::I_LEN];
  assign readout_coding     = act[swb_pkg::I_READOUT];
  assign signal_sample_time = act[swb_pkg::I_SHS];
  assign reset_sample_time  = act[swb_pkg::I_SHR];
  assign line_clock_delay   = act[swb_pkg::I_HCLK];
  assign pixel_stream_ctrl  = act[swb_pkg::I_PIX];
  assign frame_rate_ctrl    = act[swb_pkg::I_FRC];

  // checks on the live behaviour
  unused_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R18
    (reg_rd && !reg_wr && (reg_addr >= 8'hc0)) |-> ##2 (reg_rvalid && reg_rdata == 8'h00))
    else $error("unused address did not read zero");
  shadow_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    !frame_boundary |=> ($stable(line_clock_delay) && $stable(vframe_width) && $stable(act[0])))
    else $error("shadowed value changed mid-frame");
  shadow_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    frame_boundary |=> (signal_sample_time == $past(cfg[swb_pkg::I_SHS])))
    else $error("shadowed value not loaded at frame boundary");
  direct_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    (reg_wr && reg_addr == 8'h54) |=> (frame_start_delay == $past(reg_wdata)))
    else $error("unshadowed write did not act at once");
  code_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    (reg_wr && reg_addr == 8'h01) |=> (cfg[1] == {2'b00, $past(reg_wdata[5:0])}))
    else $error("gain code not masked to six bits");
  raw_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    ($past(rst_n) && !gain_mode_linear && act[1][5:0] <= 6'h20) |=>
      (gain_colour2 == 19'(19'd69560 + 19'd2174 * {13'h0, $past(act[1][5:0])})))
    else $error("raw low gain wrong");
  raw_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    (!gain_mode_linear && act[0][5:0] > 6'h20) |=>
      (gain_colour1 == 19'(19'd139100 + 19'd4340 * {13'h0, $past(act[0][5:0]) - 6'h20})))
    else $error("raw high gain wrong");
  linear_gain_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    ($past(rst_n) && gain_mode_linear) |=>
      (gain_colour3 == 19'(19'd69560 + 19'd4340 * {13'h0, $past(act[2][5:0])})))
    else $error("linear gain wrong");

  // read timing, staged reads, column port and the reset code's gain
  rvalid_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
    reg_rd |-> ##2 reg_rvalid)
    else $error("read valid did not follow the read strobe");
  read_staged_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    (reg_rd && !reg_wr && reg_addr == 8'h64) |-> ##2 (reg_rdata == $past(cfg[swb_pkg::I_HCLK], 2)))
    else $error("read of a shadowed register did not return the host copy");
  coeff_col_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    (reg_wr && is_coeff(reg_addr) && col_index == reg_addr[5:0]) ##1 $stable(col_index) |=>
      (col_offset == $past(reg_wdata, 2)))
    else $error("column port did not return the new coefficient");
  unity_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    ($past(rst_n) && !gain_mode_linear && act[3][5:0] == 6'h0e) |=> (gain_colour4 == 19'd99996))
    else $error("reset code does not give unity gain");

  // every register keeps its own update rule, not only the ones sampled above
  for (genvar i = 0; i < swb_pkg::NREG; i++) begin : g_follow
    if (swb_pkg::SHADOW_MASK[i]) begin : g_shadowed
      shadow_each_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        frame_boundary |=> (act[i] == $past(cfg[i])))
        else $error("shadowed copy did not load at frame boundary");
    end else begin : g_direct
      direct_each_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        (reg_wr && reg_addr == swb_pkg::ADDR_TAB[i]) |=> (act[i] == $past(reg_wdata)))
        else $error("unshadowed write did not reach its active copy");
    end
  end

  // scenarios worth seeing at least once
  cover_shadow_load: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h64) ##[1:20] frame_boundary);
  cover_coeff_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h85) ##2 (reg_rvalid && reg_rdata != 8'h00));
  cover_mode_swap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(gain_mode_linear));
  cover_knee_step: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !gain_mode_linear && act[1][5:0] == 6'h21);
  cover_unused_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr >= 8'hc0);
endmodule

/* File: swb_host_model.sv */
// host-side model driving the register access port of the bank
`timescale 1ns/1ps
module swb_host_model (
  input  wire logic       ref_clk,    // master clock
  output logic      [7:0] reg_addr,   // register address
  output logic      [7:0] reg_wdata,  // write data
  output logic            reg_wr,     // write strobe
  output logic            reg_rd,     // read strobe
  input  wire logic [7:0] reg_rdata,  // read data
  input  wire logic       reg_rvalid  // read data valid
);
  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one write; released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read; bounded wait for the valid pulse, ok stays low on timeout
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      #1;
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end
    end
  endtask
endmodule

/* File: swb_reg_bank_test.sv */
// self-checking bench for the white-balance register bank
`timescale 1ns/1ps
module swb_reg_bank_test;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        frame_boundary = 1'b0;
  logic        gain_mode_linear = 1'b0;
  logic [5:0]  col_index = 6'h00;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, col_offset, d;
  logic        reg_wr, reg_rd, reg_rvalid;
  logic [18:0] g [4];
  logic [15:0] vframe_width;
  logic [7:0]  uo [6];
  logic [7:0]  so [5];
  logic [5:0]  cd [4];
  logic [5:0]  pc;
  logic [15:0] seed = 16'h74b1;
  int          n_errors = 0;
  int          check_count = 0;
  int          k;
  // expected reset image, own copy of the register table
  localparam logic [7:0] RA [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h52, 8'h53, 8'h54, 8'h55,
                                     8'h56, 8'h57, 8'h5f, 8'h60, 8'h64, 8'h65, 8'h67};
  localparam logic [7:0] RV [15] = '{8'h0e, 8'h0e, 8'h0e, 8'h0e, 8'h05, 8'h13, 8'h4c, 8'h02,
                                     8'h0e, 8'h04, 8'h0a, 8'h0a, 8'h5c, 8'h00, 8'h24};
  localparam logic [7:0] UA [6]  = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h65, 8'h67};
  localparam logic [7:0] SA [5]  = '{8'h52, 8'h53, 8'h5f, 8'h60, 8'h64};
  localparam logic [7:0] NA [9]  = '{8'h04, 8'h58, 8'h5e, 8'h5b, 8'h7a, 8'h69, 8'h7f, 8'hc0, 8'hff};
  localparam logic [5:0] CORN [4] = '{6'h00, 6'h20, 6'h21, 6'h3f};

  always #5 ref_clk = ~ref_clk;
  // shadowed outputs grouped by address order
  assign so[0] = vframe_width[15:8];
  assign so[1] = vframe_width[7:0];

  swb_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                       .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  swb_reg_bank dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .frame_boundary(frame_boundary), .gain_mode_linear(gain_mode_linear), .col_index(col_index),
    .col_offset(col_offset), .gain_colour1(g[0]), .gain_colour2(g[1]), .gain_colour3(g[2]),
    .gain_colour4(g[3]), .vframe_width(vframe_width), .frame_start_delay(uo[0]),
    .video_clock_delay(uo[1]), .sync_pulse_len(uo[2]), .readout_coding(uo[3]),
    .signal_sample_time(so[2]), .reset_sample_time(so[3]), .line_clock_delay(so[4]),
    .pixel_stream_ctrl(uo[4]), .frame_rate_ctrl(uo[5]));

  // pseudo-random byte, fixed seed keeps runs repeatable
  function automatic logic [7:0] rb();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  // gain in units of 1e-5 for a code and mode
  function automatic logic [18:0] gain_f(input logic [5:0] c, input logic lin);
    if (lin)
      return 19'h10fb8 + 19'(c) * 19'h010f4;
    if (c <= 6'h20)
      return 19'h10fb8 + 19'(c) * 19'h0087e;
    return 19'h21f5c + 19'(c - 6'h20) * 19'h010f4;
  endfunction
  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic       ok;
    host.rd(a, v, ok);
    chk("read valid", 19'(1), 19'(ok));
    chk("read data", 19'(e), 19'(v));
  endtask
  // boundary pulse, then time for active copies and gains to follow
  task automatic frame();
    @(posedge ref_clk);
    frame_boundary <= 1'b1;
    @(posedge ref_clk);
    frame_boundary <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // overall limit on the run
  initial begin
    #500us;
    n_errors++;
    $display("[ERR] run limit expected finish seen hang");
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    for (k = 0; k < 4; k++) chk("reset gain", gain_f(6'h0e, 1'b0), g[k]);
    for (k = 0; k < 15; k++) rdchk(RA[k], RV[k]);
    rdchk(8'h80, 8'h00);
    rdchk(8'hbf, 8'h00);
    $display("test reset values done");
    // shadowed registers hold until a boundary, reads show the staged value
    for (k = 0; k < 5; k++) begin
      cd[0] = rb();
      host.wr(SA[k], {2'b00, cd[0]});
      #1;
      chk("shadow held", 19'(RV[k < 2 ? k + 4 : k + 8]), 19'(so[k]));
      rdchk(SA[k], {2'b00, cd[0]});
      frame();
      chk("shadow loaded", 19'({2'b00, cd[0]}), 19'(so[k]));
    end
    $display("test shadowed done");
    // unshadowed registers act on the write edge
    for (k = 0; k < 6; k++) begin
      d = rb();
      host.wr(UA[k], d);
      #1;
      chk("direct out", 19'(d), 19'(uo[k]));
      rdchk(UA[k], d);
    end
    $display("test unshadowed done");
    // gain codes: corner codes first, then random, both modes
    cd[0] = 6'h0e;  // colour one still holds its reset code here
    for (k = 0; k < 10; k++) begin
      pc = cd[0];
      @(posedge ref_clk);
      gain_mode_linear <= k[0];
      for (int i = 0; i < 4; i++) begin
        d = rb();
        cd[i] = (k < 4) ? CORN[(k + i) % 4] : d[5:0];
        host.wr(8'(i), {2'b11, cd[i]});
      end
      #1;
      chk("gain before boundary", gain_f(pc, k[0]), g[0]);
      frame();
      for (int i = 0; i < 4; i++) begin
        chk("colour gain", gain_f(cd[i], k[0]), g[i]);
        rdchk(8'(i), {2'b00, cd[i]});
      end
    end
    $display("test gains done");
    // column coefficients: both ends of the range, then random columns
    for (k = 0; k < 10; k++) begin
      d = rb();
      cd[0] = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : d[5:0];
      d = rb();
      @(posedge ref_clk);
      col_index <= cd[0];  // column watched before and after its write
      host.wr(8'h80 + {2'b00, cd[0]}, d);
      rdchk(8'h80 + {2'b00, cd[0]}, d);
      chk("column offset", 19'(d), 19'(col_offset));
    end
    $display("test coefficients done");
    // unused and factory places ignore writes and read zero
    for (k = 0; k < 9; k++) begin
      host.wr(NA[k], rb());
      rdchk(NA[k], 8'h00);
    end
    $display("test unused done");
    wrap_up();
  end
endmodule
